// *** src/cfg_pkg.sv ***
// Constants for the bus address and power-up configuration block.
// Assumes a single 125 MHz clock and a plain strobe register port.
package cfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_PERIOD_US  = 1000;
  localparam int TICK_CYCLES     = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int CAL_TIME_MS     = 10000;
  localparam int CAL_TICKS       = CAL_TIME_MS * 1000 / TICK_PERIOD_US;
  localparam int REPEAT_TIME_MS  = 60000;
  localparam int REPEAT_TICKS    = REPEAT_TIME_MS * 1000 / TICK_PERIOD_US;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] HEAD_FRONT_OFS  = 8'h08;
  localparam logic [7:0] HEAD_REAR_OFS   = 8'h0C;
  localparam logic [7:0] HEAD_ACTIVE_OFS = 8'h10;

  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_REAR_BIT    = 1;
  localparam int CTRL_MANUAL_BIT  = 2;
  localparam int CTRL_WATTS_BIT   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int ST_ADDR_LSB      = 0;
  localparam int ST_TALKONLY_BIT  = 5;
  localparam int ST_INVALID_BIT   = 6;
  localparam int ST_CAL_BIT       = 7;
  localparam int ST_SHOW_BIT      = 8;

  localparam logic [15:0] HEAD_RESET = 16'h4000;

  // ****************************************************************
  // Bus address coding
  // ****************************************************************
  localparam logic [7:0] LISTEN_BASE   = 8'h20;
  localparam logic [7:0] TALK_BASE     = 8'h40;
  localparam logic [4:0] ADDR_RESERVED = 5'h1F;
  localparam logic [4:0] FACTORY_ADDR  = 5'h0C;

endpackage

// *** src/addr_if.sv ***
// Carrier between the configuration top and its switch decoder.
// Assumes both ends sit in the same clock domain.
interface addr_if;
  logic [4:0] sw;
  logic       talk_only_sw;
  logic [7:0] listen_code;
  logic [7:0] talk_code;
  logic [7:0] dec_bcd;
  logic       valid;

  modport src (
    input  sw,
    input  talk_only_sw,
    output listen_code,
    output talk_code,
    output dec_bcd,
    output valid
  );

  modport user (
    output sw,
    output talk_only_sw,
    input  listen_code,
    input  talk_code,
    input  dec_bcd,
    input  valid
  );
endinterface

// *** src/addr_decode.sv ***
// Combinational decode of the rear address switches.
// Assumes the switch levels are already synchronous to the clock.
module addr_decode (
  addr_if.src port
);

  logic [3:0] tens;
  logic [3:0] units;

  // Switch value maps straight to the address, bit 0 is the right switch
  always_comb begin
    port.listen_code = cfg_pkg::LISTEN_BASE + {3'h0, port.sw}; // see RL1
    port.talk_code   = cfg_pkg::TALK_BASE + {3'h0, port.sw};   // see RL2
    tens             = 4'(port.sw / 5'h0A);
    units            = 4'(port.sw % 5'h0A);
    port.dec_bcd     = {tens, units};
    // All ones would collide with unlisten and untalk
    port.valid       = !port.talk_only_sw &&
                       (port.sw != cfg_pkg::ADDR_RESERVED); // see RL10
  end

endmodule

// *** src/meter_config.sv ***
// Bus address and power-up configuration logic of the level meter.
// Assumes synchronous switch and key inputs and one-cycle key pulses.
//
// Contract
// RL1: Address comes from five switches, right switch is bit 0, up is one.
// RL2: Listen code is space plus N, talk code is at-sign plus N.
// RL3: Factory setting twelve gives listen comma and talk L.
// RL4: Recall, shift, local key sequence shows the bus address in decimal.
// RL5: Sixth switch at one selects talk-only and ignores address switches.
// RL6: Power-up selects auto range, volts and front input, lit indicators.
// RL7: Power-up runs internal calibration, indication clears after ten seconds.
// RL8: Internal calibration repeats with indication unless inhibited.
// RL9: One stored head factor per input; the selected input's factor applies.
// RL10: All-ones switch value is invalid, reserved for unlisten and untalk.
//
// Our own choices: the address-and-strobe port and the register offsets.
module meter_config #(
  parameter int TICK_CYCLES  = cfg_pkg::TICK_CYCLES,
  parameter int CAL_TICKS    = cfg_pkg::CAL_TICKS,
  parameter int REPEAT_TICKS = cfg_pkg::REPEAT_TICKS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [4:0]  sw_addr,
  input  wire logic        sw_talk_only,
  input  wire logic        key_recall,
  input  wire logic        key_shift,
  input  wire logic        key_local,
  output logic      [7:0]  listen_addr,
  output logic      [7:0]  talk_addr,
  output logic             talk_only,
  output logic             addr_valid,
  output logic             show_addr,
  output logic      [7:0]  show_bcd,
  output logic             ind_auto,
  output logic             ind_volts,
  output logic             ind_front,
  output logic             auto_internal_calibration,
  output logic      [15:0] head_calibration_factor
);

  // ****************************************************************
  // Switch decode
  // ****************************************************************
  addr_if aif ();

  assign aif.sw           = sw_addr;
  assign aif.talk_only_sw = sw_talk_only;

  addr_decode u_dec (
    .port (aif.src)
  );

  logic [7:0] listen_reg, listen_next;
  logic [7:0] talk_reg,   talk_next;
  logic       tonly_reg,  tonly_next;
  logic       valid_reg,  valid_next;
  logic [7:0] bcd_reg,    bcd_next;

  // Register decoded addresses so outputs come from flops
  always_comb begin
    listen_next = aif.listen_code;           // see RL1
    talk_next   = aif.talk_code;             // see RL2
    tonly_next  = sw_talk_only;              // see RL5
    valid_next  = aif.valid;                 // see RL10
    bcd_next    = aif.dec_bcd;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      listen_reg <= cfg_pkg::LISTEN_BASE;
      talk_reg   <= cfg_pkg::TALK_BASE;
      tonly_reg  <= 1'b0;
      valid_reg  <= 1'b0;
      bcd_reg    <= 8'h00;
    end else begin
      listen_reg <= listen_next;
      talk_reg   <= talk_next;
      tonly_reg  <= tonly_next;
      valid_reg  <= valid_next;
      bcd_reg    <= bcd_next;
    end
  end

  // ****************************************************************
  // Key sequence for address display
  // ****************************************************************
  typedef enum logic [3:0] {
    K_IDLE   = 4'h1,
    K_RECALL = 4'h2,
    K_SHIFT  = 4'h4,
    K_SHOW   = 4'h8
  } key_state_t;

  key_state_t key_reg, key_next;
  logic       any_key;

  assign any_key = key_recall || key_shift || key_local;

  // Any key out of order restarts the sequence; a recall restarts it at once
  always_comb begin
    key_next = key_reg;
    case (key_reg)
      K_IDLE: begin
        if (key_recall) key_next = K_RECALL;
      end
      K_RECALL: begin
        if (key_shift) key_next = K_SHIFT;
        else if (any_key) key_next = key_recall ? K_RECALL : K_IDLE;
      end
      K_SHIFT: begin
        if (key_local) key_next = K_SHOW;    // see RL4
        else if (any_key) key_next = key_recall ? K_RECALL : K_IDLE;
      end
      K_SHOW: begin
        if (any_key) key_next = key_recall ? K_RECALL : K_IDLE;
      end
      default: key_next = K_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) key_reg <= K_IDLE;
    else       key_reg <= key_next;
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [3:0]  ctrl_reg,  ctrl_next;
  logic [2:0]  panel_reg, panel_next;
  logic [15:0] head_reg [2];
  logic [15:0] head_next [2];
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] fact_reg,  fact_next;
  logic        sel_rear;

  assign sel_rear = ctrl_reg[cfg_pkg::CTRL_REAR_BIT];

  // Control write; reset gives auto range, volts and the front input
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr && addr == cfg_pkg::CTRL_OFS) ctrl_next = wdata[3:0];
    // Lamps are the inverted mode bits: volts, auto, front
    panel_next = ~ctrl_next[3:1];                      // see RL6
  end

  // One stored factor per input socket; reset stands in for the
  // non-volatile backing store, which lives outside this block
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_head
      localparam logic [7:0] OFS = (gi == 0) ? cfg_pkg::HEAD_FRONT_OFS
                                             : cfg_pkg::HEAD_REAR_OFS;
      always_comb begin
        head_next[gi] = head_reg[gi];
        if (wr && addr == OFS) head_next[gi] = wdata[15:0];  // see RL9
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) head_reg[gi] <= cfg_pkg::HEAD_RESET;
        else       head_reg[gi] <= head_next[gi];
      end
    end
  endgenerate

  // Applied factor always follows the selected socket
  always_comb begin
    fact_next = head_reg[sel_rear];                    // see RL9
  end

  // Read data for the cycle after the strobe; unmapped reads are zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd) begin
      case (addr)
        cfg_pkg::CTRL_OFS:        rdata_next = {28'h0, ctrl_reg};
        cfg_pkg::STATUS_OFS: begin
          rdata_next[cfg_pkg::ST_ADDR_LSB +: 5]  = listen_reg[4:0];
          rdata_next[cfg_pkg::ST_TALKONLY_BIT]   = tonly_reg;
          rdata_next[cfg_pkg::ST_INVALID_BIT]    = !tonly_reg && !valid_reg;
          rdata_next[cfg_pkg::ST_CAL_BIT]        = auto_internal_calibration;
          rdata_next[cfg_pkg::ST_SHOW_BIT]       = key_reg == K_SHOW;
        end
        cfg_pkg::HEAD_FRONT_OFS:  rdata_next = {16'h0, head_reg[0]};
        cfg_pkg::HEAD_REAR_OFS:   rdata_next = {16'h0, head_reg[1]};
        cfg_pkg::HEAD_ACTIVE_OFS: rdata_next = {16'h0, fact_reg};
        default:                  rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg  <= cfg_pkg::CTRL_RESET;                // see RL6
      panel_reg <= ~cfg_pkg::CTRL_RESET[3:1];          // see RL6
      rdata_reg <= 32'h0000_0000;
      fact_reg  <= cfg_pkg::HEAD_RESET;
    end else begin
      ctrl_reg  <= ctrl_next;
      panel_reg <= panel_next;
      rdata_reg <= rdata_next;
      fact_reg  <= fact_next;
    end
  end

  // ****************************************************************
  // Automatic internal calibration timing
  // ****************************************************************
  typedef enum logic [1:0] {
    A_CAL  = 2'h1,
    A_WAIT = 2'h2
  } cal_state_t;

  cal_state_t  cal_reg,  cal_next;
  logic [16:0] div_reg,  div_next;
  logic [23:0] tcnt_reg, tcnt_next;
  logic        tick;

  // Millisecond enable keeps the long counters narrow
  assign tick = div_reg == 17'(TICK_CYCLES - 1);

  always_comb begin
    div_next = tick ? 17'h0_0000 : div_reg + 17'h0_0001;
  end

  // Calibrate on power-up, then idle and repeat unless inhibited
  always_comb begin
    cal_next  = cal_reg;
    tcnt_next = tcnt_reg;
    case (cal_reg)
      A_CAL: begin
        if (tick) tcnt_next = tcnt_reg + 24'h00_0001;
        if (tick && tcnt_reg == 24'(CAL_TICKS - 1)) begin    // see RL7
          cal_next  = A_WAIT;
          tcnt_next = 24'h00_0000;
        end
      end
      A_WAIT: begin
        // Inhibit clears the wait count so the repeat never fires
        if (ctrl_reg[cfg_pkg::CTRL_INHIBIT_BIT]) begin       // see RL8
          tcnt_next = 24'h00_0000;
        end else if (tick) begin
          tcnt_next = tcnt_reg + 24'h00_0001;
          if (tcnt_reg == 24'(REPEAT_TICKS - 1)) begin       // see RL8
            cal_next  = A_CAL;
            tcnt_next = 24'h00_0000;
          end
        end
      end
      default: begin
        cal_next  = A_CAL;
        tcnt_next = 24'h00_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cal_reg  <= A_CAL;                                     // see RL7
      div_reg  <= 17'h0_0000;
      tcnt_reg <= 24'h00_0000;
    end else begin
      cal_reg  <= cal_next;
      div_reg  <= div_next;
      tcnt_reg <= tcnt_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign listen_addr             = listen_reg;
  assign talk_addr               = talk_reg;
  assign talk_only               = tonly_reg;
  assign addr_valid              = valid_reg;
  assign show_addr               = key_reg[3];  // One-hot K_SHOW bit
  assign show_bcd                = bcd_reg;
  assign ind_auto                = panel_reg[1];
  assign ind_volts               = panel_reg[2];
  assign ind_front               = panel_reg[0];
  assign auto_internal_calibration = cal_reg[0];  // One-hot A_CAL bit
  assign head_calibration_factor = fact_reg;
  assign rdata                   = rdata_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_listen_map: assert property (@(posedge clk) disable iff (!rstn) // see RL1
    $past(rstn) |-> listen_addr[4:0] == $past(sw_addr))
    else $error("listen address does not follow switches");

  a_talk_map: assert property (@(posedge clk) disable iff (!rstn) // see RL2
    $past(rstn) |-> talk_addr == 8'h40 + {3'h0, $past(sw_addr)})
    else $error("talk address offset wrong");

  a_factory_pair: assert property (@(posedge clk) disable iff (!rstn) // see RL3
    ($past(rstn) && $past(sw_addr) == cfg_pkg::FACTORY_ADDR) |->
      (listen_addr == 8'h2C && talk_addr == 8'h4C))
    else $error("factory address not comma and L");

  a_key_show: assert property (@(posedge clk) disable iff (!rstn) // see RL4
    (key_recall ##1 key_shift ##1 key_local) |=>
      (show_addr && show_bcd == bcd_reg))
    else $error("address display not shown after key sequence");

  a_talk_only: assert property (@(posedge clk) disable iff (!rstn) // see RL5
    sw_talk_only |=> (talk_only && !addr_valid))
    else $error("talk-only switch not honoured");

  a_power_state: assert property (@(posedge clk) disable iff (!rstn) // see RL6
    !$past(rstn) |-> (ind_auto && ind_volts && ind_front &&
                      auto_internal_calibration))
    else $error("power-up state wrong");

  a_cal_hold: assert property (@(posedge clk) disable iff (!rstn) // see RL7
    (auto_internal_calibration && !tick) |=> auto_internal_calibration)
    else $error("calibration indication ended between ticks");

  a_inhibit: assert property (@(posedge clk) disable iff (!rstn) // see RL8
    (!auto_internal_calibration && ctrl_reg[cfg_pkg::CTRL_INHIBIT_BIT]) |=>
      !auto_internal_calibration)
    else $error("calibration repeated while inhibited");

  a_factor_sel: assert property (@(posedge clk) disable iff (!rstn) // see RL9
    $past(rstn) |-> head_calibration_factor == $past(head_reg[sel_rear]))
    else $error("applied factor not from selected socket");

  a_reserved: assert property (@(posedge clk) disable iff (!rstn) // see RL10
    (sw_addr == 5'h1F) |=> !addr_valid)
    else $error("reserved address accepted");

endmodule

// *** sim/gpib_ctrl_model.sv ***
// Behavioural bus controller that addresses the meter by number.
// Assumes the meter's codes settle one clock after the switches move.
module gpib_ctrl_model (
  input  wire logic [4:0] target,
  input  wire logic [7:0] listen_addr,
  input  wire logic [7:0] talk_addr,
  output logic      [7:0] listen_chr,
  output logic      [7:0] talk_chr,
  output logic            hit
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Address characters
  // ****************************************************************
  // The controller only reaches the meter if both characters match
  always_comb begin
    listen_chr = 8'h20 + {3'h0, target};
    talk_chr   = 8'h40 + {3'h0, target};
    hit        = (listen_addr === listen_chr) && (talk_addr === talk_chr);
  end
endmodule

// *** sim/bus_address_and_powerup_config_tb.sv ***
// Self-checking bench for the meter configuration block.
// Assumes shortened tick counts; the controller model judges addressing.
module bus_address_and_powerup_config_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Set-up
  // ****************************************************************
  localparam int TC = 4;
  localparam int AT = 5;
  localparam int RT = 8;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [4:0]  sw_addr;
  logic        sw_talk_only;
  logic        key_recall;
  logic        key_shift;
  logic        key_local;
  logic [7:0]  listen_addr;
  logic [7:0]  talk_addr;
  logic        talk_only;
  logic        addr_valid;
  logic        show_addr;
  logic [7:0]  show_bcd;
  logic        ind_auto;
  logic        ind_volts;
  logic        ind_front;
  logic        cal_busy;
  logic [15:0] factor;
  logic        hit;
  int          error_cnt;
  int          n_checks;
  int          n;
  logic [31:0] d;
  logic [15:0] ff;
  logic [15:0] fr;

  meter_config #(.TICK_CYCLES(TC), .CAL_TICKS(AT), .REPEAT_TICKS(RT))
    meter_config_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sw_addr(sw_addr),
    .sw_talk_only(sw_talk_only), .key_recall(key_recall),
    .key_shift(key_shift), .key_local(key_local),
    .listen_addr(listen_addr), .talk_addr(talk_addr),
    .talk_only(talk_only), .addr_valid(addr_valid),
    .show_addr(show_addr), .show_bcd(show_bcd), .ind_auto(ind_auto),
    .ind_volts(ind_volts), .ind_front(ind_front),
    .auto_internal_calibration(cal_busy),
    .head_calibration_factor(factor));

  gpib_ctrl_model gpib_ctrl_model_i (.target(sw_addr),
    .listen_addr(listen_addr), .talk_addr(talk_addr),
    .listen_chr(), .talk_chr(), .hit(hit));

  // Free-running bench clock
  always #4 clk = ~clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic press(input logic [2:0] k);
    @(posedge clk);
    {key_recall, key_shift, key_local} <= k;
    @(posedge clk);
    {key_recall, key_shift, key_local} <= 3'h0;
    #1;
  endtask

  task automatic set_sw(input logic [4:0] v, input logic to);
    @(posedge clk);
    sw_addr      <= v;
    sw_talk_only <= to;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the calibration indication to reach a level
  task automatic wait_cal(input logic lvl, output int cnt);
    cnt = 0;
    while (cal_busy !== lvl && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Whole sequence takes well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {addr, wdata, wr, rd} = '0;
    {key_recall, key_shift, key_local} = 3'h0;
    sw_addr = 5'h0C;
    sw_talk_only = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    d = $urandom(24);
    repeat (5) @(posedge clk);
    chk({ind_auto, ind_volts, ind_front}, 3'h7, "power-up panel");
    chk(cal_busy, 1'b1, "power-up calibration");
    rstn <= 1'b1;
    // Calibration lasts the tick budget, then repeats after the interval
    wait_cal(1'b0, n);
    chk(n >= AT * TC - 2 && n <= AT * TC + 4, 1, "first cal");
    chk({listen_addr, talk_addr}, 16'h2C4C, "factory codes");
    wait_cal(1'b1, n);
    chk(n >= RT * TC - 2 && n <= RT * TC + 4, 1, "repeat cal");
    wait_cal(1'b0, n);
    wr_reg(cfg_pkg::CTRL_OFS, 32'h1);
    n = 0;
    repeat (3 * RT * TC) begin
      @(posedge clk);
      #1;
      n += int'(cal_busy);
    end
    chk(n, 0, "inhibited repeats");
    rd_reg(cfg_pkg::STATUS_OFS, d);
    chk(d[7], 1'b0, "status calibration idle");
    wr_reg(cfg_pkg::CTRL_OFS, 32'h0);
    // Every switch value, the reserved all-ones one included
    for (int i = 0; i < 32; i++) begin
      set_sw(5'(i), 1'b0);
      chk(listen_addr, 8'h20 + 8'(i), "listen code");
      chk(talk_addr, 8'h40 + 8'(i), "talk code");
      chk(hit, 1'b1, "controller reach");
      chk(addr_valid, i != 31, "address valid");
      rd_reg(cfg_pkg::STATUS_OFS, d);
      chk(d[6:0], {i == 31, 1'b0, 5'(i)}, "status address");
    end
    // Talk-only overrides whatever the five switches say
    repeat (8) begin
      set_sw(5'($urandom), 1'b1);
      chk({talk_only, addr_valid}, 2'h2, "talk only");
    end
    // Key sequence shows the address; a wrong key drops back to idle
    n = $urandom % 31;
    set_sw(5'(n), 1'b0);
    press(3'h4);
    press(3'h2);
    press(3'h1);
    chk({show_addr, show_bcd}, {1'b1, bcd(n)}, "address shown");
    press(3'h4);
    chk(show_addr, 1'b0, "display cleared");
    press(3'h1);
    chk(show_addr, 1'b0, "broken sequence");
    // Back-to-back keys with no idle cycle between them
    @(posedge clk);
    key_recall <= 1'b1;
    @(posedge clk);
    key_recall <= 1'b0;
    key_shift  <= 1'b1;
    @(posedge clk);
    key_shift <= 1'b0;
    key_local <= 1'b1;
    @(posedge clk);
    key_local <= 1'b0;
    rd_reg(cfg_pkg::STATUS_OFS, d);
    chk(d[8], 1'b1, "status shows display");
    chk({show_addr, show_bcd}, {1'b1, bcd(n)}, "quick keys");
    // Per-socket head factors, reset defaults first
    rd_reg(cfg_pkg::HEAD_FRONT_OFS, d);
    chk(d, 32'h4000, "front factor reset");
    rd_reg(cfg_pkg::HEAD_REAR_OFS, d);
    chk(d, 32'h4000, "rear factor reset");
    ff = 16'($urandom);
    fr = ~ff;
    wr_reg(cfg_pkg::HEAD_FRONT_OFS, {16'h0, ff});
    wr_reg(cfg_pkg::HEAD_REAR_OFS, {16'h0, fr});
    #1;
    chk(factor, ff, "front factor applied");
    wr_reg(cfg_pkg::CTRL_OFS, 32'hE);
    @(posedge clk);
    #1;
    chk(factor, fr, "rear factor applied");
    chk({ind_auto, ind_volts, ind_front}, 3'h0, "panel follows");
    rd_reg(cfg_pkg::HEAD_ACTIVE_OFS, d);
    chk(d, {16'h0, fr}, "active factor");
    rd_reg(cfg_pkg::HEAD_FRONT_OFS, d);
    chk(d, {16'h0, ff}, "front factor kept");
    rd_reg(cfg_pkg::CTRL_OFS, d);
    chk(d, 32'hE, "control readback");
    rd_reg(8'hFC, d);
    chk(d, 32'h0, "unmapped read");
    // A power cycle in mid-run restores the power-up panel and calibration
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk({ind_auto, ind_volts, ind_front}, 3'h7, "panel reset");
    chk(cal_busy, 1'b1, "calibration after reset");
    print_verdict();
  end
endmodule
